//--- core/input_capture_channel.sv
// Purpose: one input capture channel behind an AXI4-Lite slave
// Assumes: timers, interrupt flag and sleep/idle state are outside
// Notes:   control at 0x0, buffer port at 0x4, others SLVERR
//
// Chosen here: the address map and register access over AXI4-Lite.
`default_nettype none
module input_capture_channel (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        capture_input_pin,
	input  wire logic [15:0] first_timebase_count,
	input  wire logic [15:0] second_timebase_count,
	input  wire logic        cpu_idle,
	input  wire logic        cpu_sleep,
	output logic             capture_irq,
	output logic             wake_request
);
	logic [15:0] ctrl;
	logic        overflow_flag;
	logic [3:0]  prescale;
	logic [1:0]  event_count;
	logic [2:0]  reads_since_ovf;
	logic        aw_held;
	logic [3:0]  aw_addr;
	logic        w_held;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        irq_pulse;
	logic        wake_pulse;
	logic        rise;
	logic        fall;
	logic [15:0] fifo_head;
	logic [2:0]  fifo_count;

	function automatic logic [15:0] merge_half(input logic [15:0] old,
		input logic [15:0] data, input logic [1:0] strb);
		logic [15:0] r;
		r = old;
		if (strb[0])
			r[7:0] = data[7:0];
		if (strb[1])
			r[15:8] = data[15:8];
		return r;
	endfunction : merge_half

	// mode decoding
	wire [2:0] capture_mode_select = ctrl[2:0];
	wire [1:0] events_per_interrupt = ctrl[capture_pkg::epi_lsb +: 2];
	wire       timebase_select = ctrl[capture_pkg::timebase_bit];
	wire       idle_stop_select = ctrl[capture_pkg::idle_stop_bit];
	wire       disabled = capture_mode_select == capture_pkg::mode_off
		|| capture_mode_select == capture_pkg::mode_unused;
	wire       halted = idle_stop_select && cpu_idle;
	wire       active = !disabled && !halted
		&& capture_mode_select != capture_pkg::mode_wake;
	wire       is_both = capture_mode_select == capture_pkg::mode_both;
	wire       is_div4 = capture_mode_select == capture_pkg::mode_div4;
	wire       is_div16 = capture_mode_select == capture_pkg::mode_div16;
	wire [3:0] prescale_last = is_div4 ? capture_pkg::div4_last
		: capture_pkg::div16_last;

	// capture event selection
	wire edge_event = (is_both && (rise || fall))
		|| (capture_mode_select == capture_pkg::mode_fall && fall)
		|| (capture_mode_select == capture_pkg::mode_rise && rise)
		|| ((is_div4 || is_div16) && rise
			&& prescale == prescale_last);
	wire capture_event = active && edge_event;
	wire [15:0] stamp = timebase_select ? first_timebase_count
		: second_timebase_count;
	wire fifo_full = fifo_count == 3'(capture_pkg::fifo_depth);
	// both-edge mode never reports overflow
	wire overflow_event = capture_event && fifo_full && !is_both;

	// interrupt decision
	wire every_event = is_both || events_per_interrupt == 2'b00;
	wire count_done = event_count == events_per_interrupt;
	wire irq_blocked = (overflow_flag || overflow_event)
		&& !every_event;
	wire next_irq = capture_event && (every_event || count_done)
		&& !irq_blocked;
	wire next_wake = !disabled && rise
		&& capture_mode_select == capture_pkg::mode_wake
		&& (cpu_idle || cpu_sleep);

	// bus decoding
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire wr_go = aw_held && w_held && !s_axi_bvalid;
	wire ar_take = s_axi_arvalid && s_axi_arready;
	wire rd_ctrl = s_axi_araddr == capture_pkg::ctrl_offset;
	wire rd_buf = s_axi_araddr == capture_pkg::buffer_offset;
	wire buffer_pop = ar_take && rd_buf;
	wire wr_ctrl = wr_go && aw_addr == capture_pkg::ctrl_offset;
	wire wr_ok = wr_go && (aw_addr == capture_pkg::ctrl_offset
		|| aw_addr == capture_pkg::buffer_offset);
	wire [15:0] written = merge_half(ctrl, w_data[15:0], w_strb[1:0]);
	wire [15:0] next_ctrl = (ctrl & ~capture_pkg::writable_mask)
		| (written & capture_pkg::writable_mask);
	wire buffer_not_empty_flag = fifo_count != 3'h0;
	wire [15:0] ctrl_view = {ctrl[15:5], overflow_flag,
		buffer_not_empty_flag, ctrl[2:0]};

	assign s_axi_awready = !aw_held;
	assign s_axi_wready = !w_held;
	assign s_axi_arready = !s_axi_rvalid;
	assign capture_irq = irq_pulse;
	assign wake_request = wake_pulse;

	capture_edge_detect u_edge (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pin     (capture_input_pin),
		.rise    (rise),
		.fall    (fall)
	);

	capture_fifo u_fifo (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.flush     (disabled),
		.push      (capture_event),
		.push_data (stamp),
		.pop       (buffer_pop),
		.head      (fifo_head),
		.count     (fifo_count)
	);

	// write channel capture; address and data in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 4'h0;
			w_data  <= 32'h0;
			w_strb  <= 4'h0;
		end else begin
			if (aw_take) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_held <= 1'b0;
			end
			if (w_take) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_go) begin
				w_held <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= capture_pkg::resp_okay;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_ok ? capture_pkg::resp_okay
				: capture_pkg::resp_slverr;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= capture_pkg::resp_okay;
		end else if (ar_take) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_ctrl ? {16'h0, ctrl_view}
				: rd_buf ? {16'h0, fifo_head} : 32'h0;
			s_axi_rresp  <= (rd_ctrl || rd_buf) ? capture_pkg::resp_okay
				: capture_pkg::resp_slverr;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= capture_pkg::ctrl_reset;
		end else if (wr_ctrl) begin
			ctrl <= next_ctrl;
		end
	end

	// overflow: set wins over the fourth-read clear
	always_ff @(posedge aclk) begin
		if (!aresetn || disabled) begin
			overflow_flag   <= 1'b0;
			reads_since_ovf <= 3'h0;
		end else if (overflow_event) begin
			overflow_flag   <= 1'b1;
			reads_since_ovf <= 3'h0;
		end else if (overflow_flag && buffer_pop) begin
			reads_since_ovf <= reads_since_ovf + 3'h1;
			if (reads_since_ovf == 3'h3)
				overflow_flag <= 1'b0;
		end
	end

	// counters restart when disabled so a new mode starts clean
	always_ff @(posedge aclk) begin
		if (!aresetn || disabled) begin
			prescale    <= 4'h0;
			event_count <= 2'h0;
		end else begin
			if (active && (is_div4 || is_div16) && rise)
				prescale <= (prescale == prescale_last) ? 4'h0
					: prescale + 4'h1;
			if (capture_event)
				event_count <= (every_event || count_done) ? 2'h0
					: event_count + 2'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_pulse  <= 1'b0;
			wake_pulse <= 1'b0;
		end else begin
			irq_pulse  <= next_irq;
			wake_pulse <= next_wake;
		end
	end

	off_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
		disabled |=> !capture_irq && fifo_count == 3'h0)
		else $error("disabled channel still active");
	both_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(is_both && active && (rise || fall)) |=> capture_irq)
		else $error("edge mode missed interrupt");
	fall_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(capture_mode_select == capture_pkg::mode_fall && rise && !fall
		&& !buffer_pop) |=> fifo_count == $past(fifo_count))
		else $error("falling mode captured on rise");
	stamp_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(capture_event && fifo_count == 3'h0 && !buffer_pop) |=>
		fifo_head == $past(stamp))
		else $error("wrong time base captured");
	ovf_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(overflow_event && !buffer_pop) |=> overflow_flag
		&& fifo_count == 3'(capture_pkg::fifo_depth))
		else $error("overflow not flagged");
	ovf_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(overflow_flag && !every_event) |=> !capture_irq)
		else $error("interrupt during overflow");
	wake_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(capture_mode_select == capture_pkg::mode_wake && !buffer_pop)
		|=> fifo_count == $past(fifo_count))
		else $error("wake mode captured");
	reserved_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl[15:14] == 2'h0 && ctrl[12:8] == 5'h0)
		else $error("reserved bits set");
	halt_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
		halted |-> !capture_event)
		else $error("captured while halted");
	not_empty_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl_view[capture_pkg::not_empty_bit] == (fifo_count != 3'h0))
		else $error("not-empty flag wrong");
	rise_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(capture_mode_select == capture_pkg::mode_rise && fall && !rise
		&& !buffer_pop) |=> fifo_count == $past(fifo_count))
		else $error("rising mode captured on fall");
	both_store_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(is_both && active && (rise || fall) && fifo_count == 3'h0
		&& !buffer_pop) |=> fifo_count == 3'h1)
		else $error("edge mode missed capture");
	div_skip_a: assert property (@(posedge aclk) disable iff (!aresetn)
		((is_div4 || is_div16) && rise && prescale != prescale_last
		&& !buffer_pop) |=> fifo_count == $past(fifo_count))
		else $error("prescaled mode captured early");
	irq_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(capture_event && !every_event && !count_done) |=> !capture_irq)
		else $error("interrupt before event count");
	irq_bound_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!every_event |-> event_count <= events_per_interrupt)
		else $error("event counter past its limit");
	ovf_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(overflow_flag && buffer_pop && reads_since_ovf == 3'h3
		&& !overflow_event && !disabled) |=> !overflow_flag)
		else $error("overflow kept after fourth read");
	ovf_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(overflow_flag && !buffer_pop && !disabled) |=> overflow_flag)
		else $error("overflow dropped without read");
	flush_a: assert property (@(posedge aclk) disable iff (!aresetn)
		disabled |=> !overflow_flag)
		else $error("overflow kept while disabled");
	pop_shift_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(buffer_pop && fifo_count != 3'h0 && !capture_event && !disabled)
		|=> fifo_count == $past(fifo_count) - 3'h1)
		else $error("buffer read did not pop");
	wake_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
		capture_mode_select != capture_pkg::mode_wake |=> !wake_request)
		else $error("wake request outside wake mode");
	rdata_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid
		&& $stable(s_axi_rdata))
		else $error("read data not held");
endmodule : input_capture_channel
`default_nettype wire

//--- core/capture_pkg.sv
// Purpose: shared constants for the input capture channel
// Assumes: 32-bit AXI4-Lite register access, one aligned word each
// Notes:   field positions of the control word and the map live here
`default_nettype none
package capture_pkg;
	localparam logic [3:0]  ctrl_offset      = 4'h0;
	localparam logic [3:0]  buffer_offset    = 4'h4;
	localparam logic [15:0] ctrl_reset       = 16'h0000;
	localparam int          idle_stop_bit    = 13;
	localparam int          timebase_bit     = 7;
	localparam int          epi_lsb          = 5;
	localparam int          overflow_bit     = 4;
	localparam int          not_empty_bit    = 3;
	localparam logic [15:0] writable_mask    = 16'h20e7;
	localparam int          fifo_depth       = 4;
	localparam logic [3:0]  div4_last        = 4'h3;
	localparam logic [3:0]  div16_last       = 4'hf;
	localparam logic [1:0]  resp_okay        = 2'b00;
	localparam logic [1:0]  resp_slverr      = 2'b10;

	typedef enum logic [2:0] {
		mode_off     = 3'b000,
		mode_both    = 3'b001,
		mode_fall    = 3'b010,
		mode_rise    = 3'b011,
		mode_div4    = 3'b100,
		mode_div16   = 3'b101,
		mode_unused  = 3'b110,
		mode_wake    = 3'b111
	} capture_mode_e;
endpackage : capture_pkg
`default_nettype wire

//--- core/capture_edge_detect.sv
// Purpose: synchronise the capture input and flag its edges
// Assumes: input may be asynchronous to aclk
// Notes:   edges come two cycles after the pin changes
`default_nettype none
module capture_edge_detect (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic pin,
	output logic      rise,
	output logic      fall
);
	logic sync_first;
	logic sync_second;
	logic last;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_first  <= 1'b0;
			sync_second <= 1'b0;
			last        <= 1'b0;
		end else begin
			sync_first  <= pin;
			sync_second <= sync_first;
			last        <= sync_second;
		end
	end

	assign rise = sync_second & ~last;
	assign fall = ~sync_second & last;
endmodule : capture_edge_detect
`default_nettype wire

//--- core/capture_fifo.sv
// Purpose: four-entry timestamp store that shifts toward the head
// Assumes: push is dropped when full, pop ignored when empty
// Notes:   head entry always at index 0
`default_nettype none
module capture_fifo (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        flush,
	input  wire logic        push,
	input  wire logic [15:0] push_data,
	input  wire logic        pop,
	output logic [15:0]      head,
	output logic [2:0]       count
);
	logic [15:0] slot [capture_pkg::fifo_depth];
	logic [2:0]  next_count;
	wire         do_pop  = pop && (count != 3'h0);
	wire         full    = count == 3'(capture_pkg::fifo_depth);
	wire         do_push = push && !full;
	wire  [2:0]  base    = do_pop ? count - 3'h1 : count;

	assign next_count = base + {2'h0, do_push};
	assign head = slot[0];

	always_ff @(posedge aclk) begin
		if (!aresetn || flush) begin
			count <= 3'h0;
		end else begin
			count <= next_count;
		end
	end

	// shift first, then write at the post-pop tail
	always_ff @(posedge aclk) begin
		for (int i = 0; i < capture_pkg::fifo_depth; i++) begin
			if (do_pop && i < capture_pkg::fifo_depth - 1)
				slot[i] <= slot[i+1];
			if (do_push && base == 3'(i))
				slot[i] <= push_data;
		end
	end
endmodule : capture_fifo
`default_nettype wire

//--- test/pin_source.sv
// Purpose: far-side model, a signal source on the capture pin
// Assumes: start sampled on aclk, pulses never zero
// Notes:   pulses are four cycles high then four low, so both
//          levels last well beyond any minimum pin high/low time
`default_nettype none
module pin_source (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       start,
	input  wire logic [4:0] pulses,
	output logic            pin,
	output logic            busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] left;
	logic [2:0] phase;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin   <= 1'b0;
			busy  <= 1'b0;
			left  <= 5'h0;
			phase <= 3'h0;
		end else if (start && !busy) begin
			busy  <= 1'b1;
			left  <= pulses;
			phase <= 3'h0;
		end else if (busy) begin
			// pin rests low between trains
			pin   <= !phase[2];
			phase <= phase + 3'h1;
			if (phase == 3'h7) begin
				left <= left - 5'h1;
				if (left == 5'h1) begin
					busy <= 1'b0;
				end
			end
		end
	end
endmodule : pin_source
`default_nettype wire

//--- test/tb.sv
// Purpose: self-checking bench for the input capture channel
// Assumes: pin_source drives the pin, timers held still per train
// Notes:   timer values are random, so each capture is predictable
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [3:0] ctl_a = capture_pkg::ctrl_offset;
	localparam logic [3:0] buf_a = capture_pkg::buffer_offset;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [3:0]  awaddr = 4'h0;
	logic [3:0]  araddr = 4'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata, rd;
	logic [1:0]  bresp, rresp, rs;
	logic        idle = 1'b0, sleep = 1'b0, start = 1'b0;
	logic        pin, irq, wake, busy, tsel;
	logic [4:0]  pulses = 5'h0;
	logic [15:0] first_cnt = 16'h0, second_cnt = 16'h0;
	logic [15:0] ts_a, ts_b, last_ts;
	logic [15:0] q[$];
	int          n_fail = 0, checked = 0, n_irq = 0, n_wake = 0;
	int          m, e, i;

	input_capture_channel u_dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .capture_input_pin(pin),
		.first_timebase_count(first_cnt),
		.second_timebase_count(second_cnt),
		.cpu_idle(idle), .cpu_sleep(sleep),
		.capture_irq(irq), .wake_request(wake)
	);
	pin_source u_src (
		.aclk(aclk), .aresetn(aresetn), .start(start),
		.pulses(pulses), .pin(pin), .busy(busy)
	);

	always #2 aclk = ~aclk;
	always @(posedge aclk) begin
		if (irq === 1'b1) n_irq++;
		if (wake === 1'b1) n_wake++;
	end

	function automatic int caps(input int md);
		case (md)
			1: return 4;
			2, 3: return 2;
			4, 5: return 1;
			default: return 0;
		endcase
	endfunction : caps

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : final_report

	task automatic stall;
		n_fail++;
		$display("MISMATCH wait bound expected answer seen none");
		final_report();
	endtask : stall

	task automatic chk(input string what, input logic [31:0] exp,
			input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		int k;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (k = 0; k < 100; k++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		rs = bresp;
		if (k == 100) stall();
	endtask : wr

	task automatic rd_reg(input logic [3:0] a);
		int k;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (k = 0; k < 100; k++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		rd = rdata;
		rs = rresp;
		if (k == 100) stall();
	endtask : rd_reg

	// always passes through off first, so stale counters cannot leak
	task automatic setup(input int md, input int ep, input int extra);
		wr(ctl_a, 32'h0);
		wr(ctl_a, 32'(md) | 32'(ep << 5) | (32'(tsel) << 7) | 32'(extra));
		n_irq = 0;
		n_wake = 0;
	endtask : setup

	task automatic pulse_ts(input logic [4:0] n);
		int k;
		@(posedge aclk);
		ts_a = 16'($urandom);
		ts_b = 16'($urandom);
		first_cnt <= ts_a;
		second_cnt <= ts_b;
		last_ts = tsel ? ts_a : ts_b;
		start <= 1'b1;
		pulses <= n;
		@(posedge aclk);
		start <= 1'b0;
		repeat (2) @(posedge aclk);
		for (k = 0; k < 300 && busy; k++) @(posedge aclk);
		if (k == 300) stall();
		// covers the two-flop sync, compare and fifo write
		repeat (6) @(posedge aclk);
	endtask : pulse_ts

	task automatic drain;
		rd_reg(ctl_a);
		chk("not empty", 32'(q.size() != 0), 32'(rd[3]));
		while (q.size() != 0) begin
			rd_reg(buf_a);
			chk("buffer", {16'h0, q.pop_front()}, rd);
		end
		rd_reg(ctl_a);
		chk("empty", 32'h0, 32'(rd[3]));
	endtask : drain

	initial begin
		void'($urandom(60));
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd_reg(ctl_a);
		chk("ctrl reset", 32'h0, rd);
		wr(ctl_a, 32'hffff_fff8);
		rd_reg(ctl_a);
		chk("ctrl mask", 32'h0000_20e0, rd);
		wr(buf_a, 32'h1234);
		chk("buffer write resp", 32'(capture_pkg::resp_okay), 32'(rs));
		rd_reg(4'h8);
		chk("unmapped resp", 32'(capture_pkg::resp_slverr), 32'(rs));
		chk("unmapped data", 32'h0, rd);
		for (m = 0; m < 7; m++) begin
			tsel = 1'($urandom);
			setup(m, 0, 0);
			pulse_ts((m == 4) ? 5'd4 : (m == 5) ? 5'd16 : 5'd2);
			chk("mode irqs", 32'(caps(m)), 32'(n_irq));
			repeat (caps(m)) q.push_back(last_ts);
			drain();
		end
		setup(7, 3, 0);
		sleep <= 1'b1;
		pulse_ts(5'd1);
		chk("wake pulse", 32'h1, 32'(n_wake));
		sleep <= 1'b0;
		pulse_ts(5'd1);
		chk("wake awake", 32'h1, 32'(n_wake));
		chk("wake irqs", 32'h0, 32'(n_irq));
		drain();
		for (e = 0; e < 4; e++) begin
			tsel = 1'($urandom);
			setup(3, e, 0);
			for (i = 0; i < 4; i++) begin
				pulse_ts(5'd1);
				q.push_back(last_ts);
			end
			chk("irq per events", 32'(4 / (e + 1)), 32'(n_irq));
			drain();
		end
		for (e = 1; e >= 0; e--) begin
			setup(3, e, 0);
			for (i = 0; i < 4; i++) begin
				pulse_ts(5'd1);
				q.push_back(last_ts);
			end
			pulse_ts(5'd1);
			chk("irq overflowed", (e == 0) ? 32'd5 : 32'd2, 32'(n_irq));
			for (i = 0; i < 4; i++) begin
				rd_reg(ctl_a);
				chk("overflow set", 32'h1, 32'(rd[4]));
				rd_reg(buf_a);
				chk("kept entry", {16'h0, q.pop_front()}, rd);
			end
			rd_reg(ctl_a);
			chk("overflow clear", 32'h0, 32'(rd[4]));
		end
		setup(3, 0, 32'h2000);
		idle <= 1'b1;
		pulse_ts(5'd1);
		chk("idle halted", 32'h0, 32'(n_irq));
		setup(3, 0, 0);
		pulse_ts(5'd1);
		q.push_back(last_ts);
		chk("idle running", 32'h1, 32'(n_irq));
		drain();
		idle <= 1'b0;
		pulse_ts(5'd1);
		wr(ctl_a, 32'h0);
		rd_reg(ctl_a);
		chk("flags on disable", 32'h0, rd);
		final_report();
	end
endmodule : tb
`default_nettype wire
